// ===== design/gpt_one_shot.sv
// one channel position timer: down-counter loaded on fire
`timescale 1ns/1ps
module gpt_one_shot #(
  parameter int CNT_W = gpt_pkg::CNT_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_fire,
  input  wire logic [CNT_W-1:0] i_load,
  output logic                  o_busy
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } gpt_os_t;

  gpt_os_t st_r;
  gpt_os_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_fire) begin
      st_nxt.cnt = i_load;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_busy = (st_r.cnt != '0);

  a_busy_after_fire: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_fire && i_load != '0 |=> o_busy)
    else $error("timer not busy after fire");

  a_load_value: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_fire |=> st_r.cnt == $past(i_load))
    else $error("timer count not loaded on fire");
endmodule // gpt_one_shot

// ===== design/gpt_pkg.sv
// package: constants for the game port timer readout block
package gpt_pkg;
  localparam logic [9:0] PORT_ADDR      = 10'h201;
  localparam int         ADDR_W         = 10;
  localparam int         DATA_W         = 8;
  localparam int         NCH            = 4;
  localparam int         BTN_LSB        = 4;
  localparam int         TMR_LSB        = 0;
  localparam int         CLK_HZ         = 40000000;
  // base interval in nanoseconds and slope in picoseconds per ohm
  localparam int         BASE_NS        = 24200;
  localparam int         SLOPE_PS_OHM   = 11000;
  localparam int         RES_MAX_OHM    = 100000;
  localparam int         BASE_CYC       = (BASE_NS * (CLK_HZ / 1000000)
                                           + 999) / 1000;
  localparam int         CNT_W          = 16;
  localparam int         RES_W          = 17;
  // cycles per ohm as a 16.16 fixed point factor
  localparam longint     SLOPE_FX       = (64'(SLOPE_PS_OHM) * CLK_HZ
                                           * 65536) / 64'd1000000000000;
  localparam int         FX_SH          = 16;
endpackage

// ===== design/gpt_top.sv
// top: game port select, data driver and four position timers
// Function
// - Select only when address is 0x201 and DMA hold is inactive.
// - Compare all ten address lines, bits 9 to 0.
// - DMA hold active forces select off and data driver off.
// - Drive data bus only during a selected read, else released.
// - Selected write fires timers; selected read returns buttons and timers.
// - Buttons appear on data bits 7 to 4.
// - Open button reads 1, grounded button reads 0.
// - No debounce in hardware; software filters bounce.
// - Any write to the port fires all four timers, data ignored.
// - Timer outputs appear on data bits 3 to 0.
// - All timer bits rise together, fall independently.
// - Interval is 24.2 us plus 0.011 us per ohm, 0 to 100k.
`timescale 1ns/1ps
module gpt_top #(
  parameter int NCH   = gpt_pkg::NCH,
  parameter int RES_W = gpt_pkg::RES_W,
  parameter int CNT_W = gpt_pkg::CNT_W
) (
  // clock, reset and freeze
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  // host i/o channel
  input  wire logic [gpt_pkg::ADDR_W-1:0] i_port_address_lines,
  input  wire logic                       i_dma_address_hold,
  input  wire logic                       i_port_read_strobe_n,
  input  wire logic                       i_port_write_strobe_n,
  input  wire logic [gpt_pkg::DATA_W-1:0] i_host_data_lines,
  output logic      [gpt_pkg::DATA_W-1:0] o_host_data_lines,
  output logic                            o_host_data_oe,
  // far side: button levels and resistance codes per channel
  input  wire logic [NCH-1:0]             i_button_n,
  input  wire logic [NCH*RES_W-1:0]       i_res_ohm
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [NCH-1:0] btn_s1;
    logic [NCH-1:0] btn_s2;
    logic [NCH-1:0] btn_s3;
    logic [NCH-1:0] btn;
    logic [2:0]     wr_s;
    logic           wr_act;
    logic [gpt_pkg::DATA_W-1:0] dout;
    // length of the running high interval per channel; feeds only the
    // range checks, so synthesis is free to prune it
    logic [NCH-1:0][CNT_W-1:0] mon_len;
  } gpt_st_t;

  gpt_st_t st_r;
  gpt_st_t st_nxt;

  // ****************************************************************
  // interval arithmetic
  // ****************************************************************
  // shortest and longest interval in cycles, for the range checks
  localparam int LEN_MIN = gpt_pkg::BASE_CYC;
  localparam int LEN_MAX = gpt_pkg::BASE_CYC
                           + int'((longint'(gpt_pkg::RES_MAX_OHM)
                                   * gpt_pkg::SLOPE_FX) >>> gpt_pkg::FX_SH);

  // codes above full scale are clipped: a broken pot then reads as
  // the longest interval rather than wrapping to a short one
  function automatic logic [RES_W-1:0] gpt_clamp(
    input logic [RES_W-1:0] r
  );
    if (r > RES_W'(gpt_pkg::RES_MAX_OHM)) begin
      gpt_clamp = RES_W'(gpt_pkg::RES_MAX_OHM);
    end else begin
      gpt_clamp = r;
    end
  endfunction

  // slope part of the interval; the fixed point product is floored,
  // so a channel at full scale runs two cycles short of the exact figure
  function automatic longint gpt_scale(input logic [RES_W-1:0] r);
    gpt_scale = (longint'(gpt_clamp(r)) * gpt_pkg::SLOPE_FX)
                >>> gpt_pkg::FX_SH;
  endfunction

  // cycles for one channel: base plus slope times resistance
  function automatic logic [CNT_W-1:0] gpt_cycles(
    input logic [RES_W-1:0] r
  );
    gpt_cycles = CNT_W'(gpt_scale(r) + gpt_pkg::BASE_CYC);
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  logic           sel;
  logic           wr_rise;
  logic           fire;
  logic [NCH-1:0] busy;

  // address and hold are sampled raw: they are stable for the whole
  // strobe, and only the write strobe is synchronised; the read strobe is used raw
  assign sel = (i_port_address_lines == gpt_pkg::PORT_ADDR)
               && !i_dma_address_hold;

  // leading edge of the write strobe, once the second and third stage
  // agree; built from registered state only, so the next-state logic
  // below may use it without a loop through itself
  assign wr_rise = (st_r.wr_s[1] == st_r.wr_s[2]) && st_r.wr_s[2]
                   && !st_r.wr_act;

  // one fire per write strobe; the written byte is never looked at
  assign fire = sel && wr_rise;

  always_comb begin
    st_nxt = st_r;
    // button pins: three stages, a change counts on agreement
    st_nxt.btn_s1 = i_button_n;
    st_nxt.btn_s2 = st_r.btn_s1;
    st_nxt.btn_s3 = st_r.btn_s2;
    // plain level pass, no debounce filter beyond the synchroniser:
    // contact bounce reaches the host and software must filter it
    if (st_r.btn_s2 == st_r.btn_s3) begin
      st_nxt.btn = st_r.btn_s3;
    end
    // write strobe: same three stages as the buttons
    st_nxt.wr_s = {st_r.wr_s[1:0], !i_port_write_strobe_n};
    if (st_r.wr_s[1] == st_r.wr_s[2]) begin
      st_nxt.wr_act = st_r.wr_s[2];
    end
    // read data is refreshed every cycle, so a polling host sees each
    // timer bit fall one cycle after its counter empties
    st_nxt.dout[gpt_pkg::BTN_LSB +: NCH] = st_r.btn;
    st_nxt.dout[gpt_pkg::TMR_LSB +: NCH] = busy;
    // interval monitor for the range checks; restarts on fire so a
    // re-trigger is measured from its own start
    for (int c = 0; c < NCH; c++) begin
      if (fire || !busy[c]) begin
        st_nxt.mon_len[c] = '0;
      end else begin
        st_nxt.mon_len[c] = st_r.mon_len[c] + 1'b1;
      end
    end
  end

  // buttons reset to the open level so no false press follows reset;
  // a low clock enable freezes every stage, timers included
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{btn_s1: '1, btn_s2: '1, btn_s3: '1, btn: '1,
                default: '0};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // timers
  // ****************************************************************
  // all channels share one fire, so they rise in the same cycle and
  // each falls when its own count runs out
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      gpt_one_shot #(.CNT_W(CNT_W)) u_os (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_ce   (i_ce),
        .i_fire (fire),
        .i_load (gpt_cycles(i_res_ohm[g*RES_W +: RES_W])),
        .o_busy (busy[g])
      );
    end
  endgenerate

  // ****************************************************************
  // data driver
  // ****************************************************************
  assign o_host_data_lines = st_r.dout;
  // enable is combinational on the raw strobe so the bus is released
  // as soon as the read ends
  assign o_host_data_oe = sel && !i_port_read_strobe_n;

  // ****************************************************************
  // bus checks
  // ****************************************************************
  a_hold_no_drive: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_dma_address_hold |-> !o_host_data_oe)
    else $error("driver on while dma hold active");

  a_drive_only_sel: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_host_data_oe |-> i_port_address_lines == gpt_pkg::PORT_ADDR
                       && !i_port_read_strobe_n)
    else $error("driver on outside port read");

  a_drive_on_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    sel && !i_port_read_strobe_n |-> o_host_data_oe)
    else $error("driver off during port read");

  a_no_drive_idle: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_port_read_strobe_n |-> !o_host_data_oe)
    else $error("driver on without read strobe");

  a_no_fire_hold: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_dma_address_hold |-> !fire)
    else $error("fire while dma hold active");

  a_fire_needs_addr: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    fire |-> i_port_address_lines == gpt_pkg::PORT_ADDR)
    else $error("fire from a foreign address");

  a_fire_single: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && fire |=> !fire)
    else $error("one write strobe fired twice");

  a_fire_wr_edge: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    fire |-> !st_r.wr_act && st_r.wr_s[2])
    else $error("fire without a write strobe edge");

  // ****************************************************************
  // data checks
  // ****************************************************************
  a_data_bits: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce |=> o_host_data_lines[gpt_pkg::TMR_LSB +: NCH] == $past(busy))
    else $error("timer bits wrong on data bus");

  a_btn_bits: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce |=> o_host_data_lines[gpt_pkg::BTN_LSB +: NCH] == $past(st_r.btn))
    else $error("button bits wrong on data bus");

  a_btn_filter: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    st_nxt.btn != st_r.btn |-> st_r.btn_s2 == st_r.btn_s3)
    else $error("button level taken before stages agree");

  a_data_freeze: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_ce |=> $stable(o_host_data_lines))
    else $error("read data moved while frozen");

  // ****************************************************************
  // timer checks
  // ****************************************************************
  a_fire_all_busy: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && fire |=> busy == '1)
    else $error("timers did not rise together");

  a_base_len: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && fire && i_res_ohm[RES_W-1:0] == '0 |=> busy[0][*8])
    else $error("timer interval too short");

  a_busy_freeze: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_ce |=> $stable(busy))
    else $error("timer moved while frozen");

  generate
    for (g = 0; g < NCH; g++) begin : g_chk
      a_rise_on_fire: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(busy[g]) |-> $past(fire))
        else $error("timer rose without a fire");

      a_stay_low: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !busy[g] && !fire |=> !busy[g])
        else $error("idle timer rose by itself");

      a_len_min: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $fell(busy[g]) |-> st_r.mon_len[g] >= CNT_W'(LEN_MIN))
        else $error("timer interval below base length");

      a_len_max: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        busy[g] |-> st_r.mon_len[g] <= CNT_W'(LEN_MAX))
        else $error("timer interval beyond full scale");
    end
  endgenerate
endmodule // gpt_top

// ===== dv/gpt_host_model.sv
// host i/o channel model: runs port read and write cycles
`timescale 1ns/1ps
module gpt_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_bus,
  input  wire logic       i_oe,
  output logic      [9:0] o_addr,
  output logic            o_hold,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [7:0] o_data
);
  initial begin
    o_addr = 10'h000;
    o_hold = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_data = 8'h00;
  end

  // a cycle holds address, hold and data steady for n edges of strobe
  task automatic cyc(input logic [9:0] a, input logic h, input logic w,
                     input logic [7:0] d, input int n,
                     output logic [7:0] rd, output logic roe);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_hold = h;
    o_data = d;
    if (w) o_wr_n = 1'b0; else o_rd_n = 1'b0;
    repeat (n) @(posedge i_clk);
    rd = i_bus;
    roe = i_oe;
    #1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    // released lines must not keep showing the old value
    o_data = ~d;
    o_addr = ~a;
  endtask
endmodule // gpt_host_model

// ===== dv/test_gpt_top.sv
// self-checking bench for the game port timer readout block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_gpt_top;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [9:0]  addr, av;
  logic        hold, rd_n, wr_n, oe, roe;
  logic [7:0]  hdat, bus, rv;
  logic [3:0]  btn = 4'hf;
  logic [67:0] res = '0;
  logic [31:0] seed = 32'd29;
  int          mismatches = 0, checked = 0, cyc = 0, d;
  int          cnt [4];

  initial forever #12.5 i_clk = ~i_clk;

  gpt_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_port_address_lines(addr), .i_dma_address_hold(hold),
    .i_port_read_strobe_n(rd_n), .i_port_write_strobe_n(wr_n),
    .i_host_data_lines(hdat), .o_host_data_lines(bus),
    .o_host_data_oe(oe), .i_button_n(btn), .i_res_ohm(res));
  gpt_host_model host (.i_clk(i_clk), .i_bus(bus), .i_oe(oe), .o_addr(addr),
    .o_hold(hold), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(hdat));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // interval in 25 ns cycles: 24.2 us plus 11 ns per ohm
  function automatic int exp_len(input int r);
    return 968 + (r * 44) / 100;
  endfunction

  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    `CHK("oe_idle", 1'b0, oe)
    // one-bit address misses, then the right address under dma hold
    for (int k = 0; k < 11; k++) begin
      av = (k < 10) ? (10'h201 ^ (10'h001 << k)) : 10'h201;
      host.cyc(av, k == 10, 1'b0, 8'h00, 3, rv, roe);
      `CHK("oe_miss", 1'b0, roe)
      host.cyc(av, k == 10, 1'b1, 8'(xs()), 4, rv, roe);
    end
    host.cyc(10'h201, 1'b0, 1'b0, 8'h00, 3, rv, roe);
    `CHK("oe_hit", 1'b1, roe)
    `CHK("no_fire", 4'h0, rv[3:0])
    for (int t = 0; t < 3; t++) begin
      btn = (t == 0) ? 4'h0 : 4'(xs());
      // channel g wired as A-X, A-Y, B-X, B-Y or paddle A to D
      for (int g = 0; g < 4; g++)
        res[g*17+:17] = (t == 0) ? 17'h0 : 17'(xs() % 4000);
      repeat (8) @(posedge i_clk);
      host.cyc(10'h201, 1'b0, 1'b1, 8'(xs()), 4, rv, roe);
      for (int g = 0; g < 4; g++) cnt[g] = 0;
      fork
        host.cyc(10'h201, 1'b0, 1'b0, 8'h00, 3000, rv, roe);
        begin
          repeat (3) @(posedge i_clk);
          @(negedge i_clk);
          `CHK("rise", 4'hf, bus[3:0])
          `CHK("buttons", btn, bus[7:4])
          repeat (2990) begin
            @(negedge i_clk);
            for (int g = 0; g < 4; g++) cnt[g] += int'(bus[g]);
          end
        end
      join
      for (int g = 0; g < 4; g++) begin
        d = exp_len(int'(res[g*17+:17])) - cnt[g];
        `CHK("tmr_len", 1'b1, 1'(d > -4 && d < 12))
      end
    end
    tally_and_finish();
  end
endmodule // test_gpt_top
